// File: src/emcr_regs.sv
// Indirectly addressed metering configuration, threshold and peak register bank.
`timescale 1ns/10ps

// Notes on behaviour
// RQ1 - Line-cycle count is 16-bit unsigned, resets to all ones.
// RQ2 - Sag half-cycle count is 8-bit unsigned, resets to 0xff.
// RQ3 - Sag voltage threshold is 16-bit unsigned, resets to zero.
// RQ4 - Current peak threshold is 16-bit unsigned, resets to all ones.
// RQ5 - Voltage peak threshold is 16-bit unsigned, resets to all ones.
// RQ6 - Current peak plain address reads the held peak without changing it.
// RQ7 - Current peak clearing alias returns the peak then zeroes it.
// RQ8 - Voltage peak has a plain read address and a clearing alias.
// RQ9 - Amplifier gain select is 8-bit unsigned, resets to zero.
// RQ10 - Second current matching gain is 12-bit signed, resets to zero.
// RQ11 - Active, reactive, apparent power gains are 12-bit signed, reset zero.
// RQ12 - Active and reactive power offsets are 16-bit signed, reset zero.
// RQ13 - Current and voltage rms offsets are 12-bit signed, reset zero.
// RQ14 - Three energy dividers are 8-bit unsigned, reset zero.
// RQ15 - First pulse output numerator resets zero, denominator resets 0x003f.
// RQ16 - Second pulse output numerator resets zero, denominator resets 0x003f.
// RQ17 - Zero-crossing output control is 8-bit, resets zero.
// RQ18 - Calibration mode select is 8-bit unsigned, resets zero.
// RQ19 - Software keeps reserved words at defaults, zero or 0x0300.
// RQ20 - Access goes through a pointer plus low, middle, high data bytes.
// RQ21 - Line-synchronous totals latch after the programmed half-cycle count.
// RQ22 - Narrow registers drop upper write bits; reads zero- or sign-extend.
module emcr_regs (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                sfr_wr,
	input  wire logic                sfr_rd,
	input  wire logic [7:0]          sfr_addr,
	input  wire logic [7:0]          sfr_wdata,
	output logic [7:0]               sfr_rdata_q,
	input  wire emcr_pkg::emcr_smp_t smp,
	output emcr_pkg::emcr_cfg_t      cfg_q,
	output logic [2:0][23:0]         line_energy_q,
	output logic                     line_done_q,
	output logic                     sag_q,
	output logic                     current_over_q,
	output logic                     voltage_over_q
);
	localparam emcr_pkg::emcr_cfg_t CFG_RST = '{
		line_cycle_count:       emcr_pkg::RST_LINE_CYC,
		sag_half_cycle_count:   emcr_pkg::RST_SAG_CYC,
		current_peak_threshold: emcr_pkg::RST_PK_THR,
		voltage_peak_threshold: emcr_pkg::RST_PK_THR,
		pulse_out1_denominator: emcr_pkg::RST_P_DEN,
		pulse_out2_denominator: emcr_pkg::RST_P_DEN,
		reserved_word_b:        emcr_pkg::RST_RSVD_B,
		default:                '0
	};

	// Pointer and data byte registers seen by the core.
	logic [7:0]  ptr_q;
	logic [7:0]  dat_low_q;
	logic [7:0]  dat_mid_q;
	logic [7:0]  dat_high_q;
	logic [7:0]  dat_low_d;
	logic [7:0]  dat_mid_d;
	logic [7:0]  dat_high_d;
	logic [7:0]  sfr_rdata_d;

	emcr_pkg::emcr_cfg_t cfg_d;

	// Sag detector state.
	logic [7:0]  sag_cnt_q;
	logic [7:0]  sag_cnt_d;
	logic        half_high_q;
	logic        sag_d;

	// Decoded core strobes.
	wire         ptr_wr;
	wire         ind_wr;
	wire         ind_rd;
	wire  [6:0]  ind_addr;
	wire  [23:0] wd;
	wire         wr_dat_low;
	wire         wr_dat_mid;
	wire         wr_dat_high;
	wire         clr_current_peak_value;
	wire         clr_voltage_peak_value;
	wire  [23:0] current_peak_value;
	wire  [23:0] voltage_peak_value;
	logic [23:0] rd_word;

	// RQ20 pointer write triggers
	assign ptr_wr      = sfr_wr && (sfr_addr == emcr_pkg::SFR_PTR);
	assign ind_wr      = ptr_wr && sfr_wdata[emcr_pkg::PTR_WR_BIT];
	assign ind_rd      = ptr_wr && !sfr_wdata[emcr_pkg::PTR_WR_BIT];
	assign ind_addr    = sfr_wdata[6:0];
	assign wd          = {dat_high_q, dat_mid_q, dat_low_q};
	assign wr_dat_low  = sfr_wr && (sfr_addr == emcr_pkg::SFR_DAT_LOW);
	assign wr_dat_mid  = sfr_wr && (sfr_addr == emcr_pkg::SFR_DAT_MID);
	assign wr_dat_high = sfr_wr && (sfr_addr == emcr_pkg::SFR_DAT_HIGH);

	// RQ7 clear on alias read
	assign clr_current_peak_value = ind_rd && (ind_addr == emcr_pkg::OFF_IPK_RC);
	// RQ8 voltage clear alias
	assign clr_voltage_peak_value = ind_rd && (ind_addr == emcr_pkg::OFF_VPK_RC);

	// Indirect write decode; each register keeps only its own low bits.
	always_comb begin
		cfg_d = cfg_q;
		if (ind_wr) begin
			unique case (ind_addr)
				// RQ1 line cycle count
				emcr_pkg::OFF_LINE_CYC: cfg_d.line_cycle_count = wd[15:0];
				// RQ2 sag cycle count
				emcr_pkg::OFF_SAG_CYC:  cfg_d.sag_half_cycle_count = wd[7:0];
				// RQ3 sag threshold write
				emcr_pkg::OFF_SAG_THR:  cfg_d.sag_threshold = wd[15:0];
				// RQ4 current peak threshold
				emcr_pkg::OFF_IPK_THR:  cfg_d.current_peak_threshold = wd[15:0];
				// RQ5 voltage peak threshold
				emcr_pkg::OFF_VPK_THR:  cfg_d.voltage_peak_threshold = wd[15:0];
				// RQ9 amplifier gain write
				emcr_pkg::OFF_AMP_GAIN: cfg_d.input_amp_gain = wd[7:0];
				// RQ10 matching gain write
				emcr_pkg::OFF_I2_GAIN:  cfg_d.second_current_match_gain = wd[11:0];
				// RQ11 power gain writes
				emcr_pkg::OFF_ACT_GAIN: cfg_d.active_power_gain = wd[11:0];
				emcr_pkg::OFF_REA_GAIN: cfg_d.reactive_power_gain = wd[11:0];
				emcr_pkg::OFF_APP_GAIN: cfg_d.apparent_power_gain = wd[11:0];
				// RQ12 power offset writes
				emcr_pkg::OFF_ACT_OFS:  cfg_d.active_power_offset = wd[15:0];
				emcr_pkg::OFF_REA_OFS:  cfg_d.reactive_power_offset = wd[15:0];
				// RQ13 rms offset writes
				emcr_pkg::OFF_IRMS_OFS: cfg_d.current_rms_offset = wd[11:0];
				emcr_pkg::OFF_VRMS_OFS: cfg_d.voltage_rms_offset = wd[11:0];
				// RQ14 divider writes
				emcr_pkg::OFF_ACT_DIV:  cfg_d.active_energy_divider = wd[7:0];
				emcr_pkg::OFF_REA_DIV:  cfg_d.reactive_energy_divider = wd[7:0];
				emcr_pkg::OFF_APP_DIV:  cfg_d.apparent_energy_divider = wd[7:0];
				// RQ15 first pulse scaling
				emcr_pkg::OFF_P1_NUM:   cfg_d.pulse_out1_numerator = wd[15:0];
				emcr_pkg::OFF_P1_DEN:   cfg_d.pulse_out1_denominator = wd[15:0];
				// RQ16 second pulse scaling
				emcr_pkg::OFF_P2_NUM:   cfg_d.pulse_out2_numerator = wd[15:0];
				emcr_pkg::OFF_P2_DEN:   cfg_d.pulse_out2_denominator = wd[15:0];
				// RQ17 zero-cross control write
				emcr_pkg::OFF_ZX_CTRL:  cfg_d.zero_cross_output_ctrl = wd[7:0];
				// RQ18 calibration mode write
				emcr_pkg::OFF_CAL_MODE: cfg_d.calibration_mode_sel = wd[7:0];
				// RQ19 reserved words stored
				emcr_pkg::OFF_RSVD_A:   cfg_d.reserved_word_a = wd[7:0];
				emcr_pkg::OFF_RSVD_B:   cfg_d.reserved_word_b = wd[15:0];
				emcr_pkg::OFF_RSVD_C:   cfg_d.reserved_word_c = wd[7:0];
				emcr_pkg::OFF_RSVD_D:   cfg_d.reserved_word_d = wd[7:0];
				// Peak addresses are read only and other offsets are not here.
				default: cfg_d = cfg_q;
			endcase
		end
	end

	// Indirect read mux, addressed by the value being written to the pointer.
	always_comb begin
		rd_word = '0;
		unique case (ind_addr)
			// RQ22 zero extension
			emcr_pkg::OFF_LINE_CYC: rd_word = {8'h00, cfg_q.line_cycle_count};
			emcr_pkg::OFF_SAG_CYC:  rd_word = {16'h0000, cfg_q.sag_half_cycle_count};
			emcr_pkg::OFF_SAG_THR:  rd_word = {8'h00, cfg_q.sag_threshold};
			emcr_pkg::OFF_IPK_THR:  rd_word = {8'h00, cfg_q.current_peak_threshold};
			emcr_pkg::OFF_VPK_THR:  rd_word = {8'h00, cfg_q.voltage_peak_threshold};
			// RQ6 plain peak read
			emcr_pkg::OFF_IPK_VAL:  rd_word = current_peak_value;
			emcr_pkg::OFF_IPK_RC:   rd_word = current_peak_value;
			// RQ8 voltage peak reads
			emcr_pkg::OFF_VPK_VAL:  rd_word = voltage_peak_value;
			emcr_pkg::OFF_VPK_RC:   rd_word = voltage_peak_value;
			emcr_pkg::OFF_AMP_GAIN: rd_word = {16'h0000, cfg_q.input_amp_gain};
			// RQ22 sign extension
			emcr_pkg::OFF_I2_GAIN:
				rd_word = {{12{cfg_q.second_current_match_gain[11]}},
					cfg_q.second_current_match_gain};
			emcr_pkg::OFF_ACT_GAIN:
				rd_word = {{12{cfg_q.active_power_gain[11]}}, cfg_q.active_power_gain};
			emcr_pkg::OFF_REA_GAIN:
				rd_word = {{12{cfg_q.reactive_power_gain[11]}}, cfg_q.reactive_power_gain};
			emcr_pkg::OFF_APP_GAIN:
				rd_word = {{12{cfg_q.apparent_power_gain[11]}}, cfg_q.apparent_power_gain};
			emcr_pkg::OFF_ACT_OFS:
				rd_word = {{8{cfg_q.active_power_offset[15]}}, cfg_q.active_power_offset};
			emcr_pkg::OFF_REA_OFS:
				rd_word = {{8{cfg_q.reactive_power_offset[15]}},
					cfg_q.reactive_power_offset};
			emcr_pkg::OFF_IRMS_OFS:
				rd_word = {{12{cfg_q.current_rms_offset[11]}}, cfg_q.current_rms_offset};
			emcr_pkg::OFF_VRMS_OFS:
				rd_word = {{12{cfg_q.voltage_rms_offset[11]}}, cfg_q.voltage_rms_offset};
			emcr_pkg::OFF_ACT_DIV:  rd_word = {16'h0000, cfg_q.active_energy_divider};
			emcr_pkg::OFF_REA_DIV:  rd_word = {16'h0000, cfg_q.reactive_energy_divider};
			emcr_pkg::OFF_APP_DIV:  rd_word = {16'h0000, cfg_q.apparent_energy_divider};
			emcr_pkg::OFF_P1_NUM:   rd_word = {8'h00, cfg_q.pulse_out1_numerator};
			emcr_pkg::OFF_P1_DEN:   rd_word = {8'h00, cfg_q.pulse_out1_denominator};
			emcr_pkg::OFF_P2_NUM:   rd_word = {8'h00, cfg_q.pulse_out2_numerator};
			emcr_pkg::OFF_P2_DEN:   rd_word = {8'h00, cfg_q.pulse_out2_denominator};
			emcr_pkg::OFF_ZX_CTRL:  rd_word = {16'h0000, cfg_q.zero_cross_output_ctrl};
			emcr_pkg::OFF_CAL_MODE: rd_word = {16'h0000, cfg_q.calibration_mode_sel};
			emcr_pkg::OFF_RSVD_A:   rd_word = {16'h0000, cfg_q.reserved_word_a};
			emcr_pkg::OFF_RSVD_B:   rd_word = {8'h00, cfg_q.reserved_word_b};
			emcr_pkg::OFF_RSVD_C:   rd_word = {16'h0000, cfg_q.reserved_word_c};
			emcr_pkg::OFF_RSVD_D:   rd_word = {16'h0000, cfg_q.reserved_word_d};
			default:                rd_word = '0;
		endcase
	end

	// RQ20 data bytes load
	always_comb begin
		dat_low_d  = dat_low_q;
		dat_mid_d  = dat_mid_q;
		dat_high_d = dat_high_q;
		if (ind_rd) begin
			dat_low_d  = rd_word[7:0];
			dat_mid_d  = rd_word[15:8];
			dat_high_d = rd_word[23:16];
		end else begin
			if (wr_dat_low) begin
				dat_low_d = sfr_wdata;
			end
			if (wr_dat_mid) begin
				dat_mid_d = sfr_wdata;
			end
			if (wr_dat_high) begin
				dat_high_d = sfr_wdata;
			end
		end
	end

	// Core read port; unknown core addresses read as zero.
	always_comb begin
		unique case (sfr_addr)
			emcr_pkg::SFR_PTR:      sfr_rdata_d = ptr_q;
			emcr_pkg::SFR_DAT_LOW:  sfr_rdata_d = dat_low_q;
			emcr_pkg::SFR_DAT_MID:  sfr_rdata_d = dat_mid_q;
			emcr_pkg::SFR_DAT_HIGH: sfr_rdata_d = dat_high_q;
			default:                sfr_rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ptr_q       <= 8'h00;
			dat_low_q   <= 8'h00;
			dat_mid_q   <= 8'h00;
			dat_high_q  <= 8'h00;
			sfr_rdata_q <= 8'h00;
			cfg_q       <= CFG_RST;
		end else begin
			if (ptr_wr) begin
				ptr_q <= sfr_wdata;
			end
			dat_low_q  <= dat_low_d;
			dat_mid_q  <= dat_mid_d;
			dat_high_q <= dat_high_d;
			if (sfr_rd) begin
				sfr_rdata_q <= sfr_rdata_d;
			end
			cfg_q <= cfg_d;
		end
	end

	// RQ6 current peak hold
	emcr_peak_hold #(
		.W (24)
	) u_current_peak_value (
		.clock   (clock),
		.rst_n   (rst_n),
		.smp_vld (smp.vld),
		.smp     (smp.i_abs),
		.thr     (cfg_q.current_peak_threshold),
		.clr     (clr_current_peak_value),
		.peak_q  (current_peak_value),
		.over_q  (current_over_q)
	);

	// RQ8 voltage peak hold
	emcr_peak_hold #(
		.W (24)
	) u_voltage_peak_value (
		.clock   (clock),
		.rst_n   (rst_n),
		.smp_vld (smp.vld),
		.smp     (smp.v_abs),
		.thr     (cfg_q.voltage_peak_threshold),
		.clr     (clr_voltage_peak_value),
		.peak_q  (voltage_peak_value),
		.over_q  (voltage_over_q)
	);

	// RQ21 line-synchronous latching
	emcr_line_accum #(
		.W  (24),
		.CH (3)
	) u_line (
		.clock       (clock),
		.rst_n       (rst_n),
		.e_vld       (smp.vld),
		.energy      ({smp.e_app, smp.e_rea, smp.e_act}),
		.zx          (smp.zx),
		.half_cycles (cfg_q.line_cycle_count),
		.total_q     (line_energy_q),
		.done_q      (line_done_q)
	);

	// RQ3 sag detector compare
	// A half cycle counts as low when no sample rose above the threshold in it.
	// Comparing the top 16 bits keeps the threshold's full range usable.
	always_comb begin
		sag_cnt_d = sag_cnt_q;
		sag_d     = sag_q;
		if (smp.zx) begin
			if (half_high_q) begin
				sag_cnt_d = 8'h00;
				sag_d     = 1'b0;
			end else if (sag_cnt_q != 8'hff) begin
				sag_cnt_d = sag_cnt_q + 8'h01;
			end
			// RQ2 sag after count
			if (!half_high_q && (sag_cnt_d >= cfg_q.sag_half_cycle_count)) begin
				sag_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sag_cnt_q   <= 8'h00;
			half_high_q <= 1'b0;
			sag_q       <= 1'b0;
		end else begin
			sag_cnt_q <= sag_cnt_d;
			sag_q     <= sag_d;
			if (smp.zx) begin
				half_high_q <= smp.vld && (smp.v_abs[23:8] > cfg_q.sag_threshold);
			end else if (smp.vld && (smp.v_abs[23:8] > cfg_q.sag_threshold)) begin
				half_high_q <= 1'b1;
			end
		end
	end
endmodule : emcr_regs

// File: src/emcr_pkg.sv
// Shared constants and carrier types for the energy meter configuration register bank.
package emcr_pkg;

	// Core-side special function register addresses.
	localparam logic [7:0] SFR_PTR      = 8'h91;
	localparam logic [7:0] SFR_DAT_LOW  = 8'h92;
	localparam logic [7:0] SFR_DAT_MID  = 8'h93;
	localparam logic [7:0] SFR_DAT_HIGH = 8'h94;
	localparam int         PTR_WR_BIT   = 7;

	// Indirect register offsets.
	localparam logic [6:0] OFF_LINE_CYC  = 7'h12;
	localparam logic [6:0] OFF_SAG_CYC   = 7'h13;
	localparam logic [6:0] OFF_SAG_THR   = 7'h14;
	localparam logic [6:0] OFF_IPK_THR   = 7'h15;
	localparam logic [6:0] OFF_VPK_THR   = 7'h16;
	localparam logic [6:0] OFF_IPK_VAL   = 7'h17;
	localparam logic [6:0] OFF_IPK_RC    = 7'h18;
	localparam logic [6:0] OFF_VPK_VAL   = 7'h19;
	localparam logic [6:0] OFF_VPK_RC    = 7'h1a;
	localparam logic [6:0] OFF_AMP_GAIN  = 7'h1b;
	localparam logic [6:0] OFF_I2_GAIN   = 7'h1c;
	localparam logic [6:0] OFF_ACT_GAIN  = 7'h1d;
	localparam logic [6:0] OFF_REA_GAIN  = 7'h1e;
	localparam logic [6:0] OFF_APP_GAIN  = 7'h1f;
	localparam logic [6:0] OFF_ACT_OFS   = 7'h20;
	localparam logic [6:0] OFF_REA_OFS   = 7'h21;
	localparam logic [6:0] OFF_IRMS_OFS  = 7'h22;
	localparam logic [6:0] OFF_VRMS_OFS  = 7'h23;
	localparam logic [6:0] OFF_ACT_DIV   = 7'h24;
	localparam logic [6:0] OFF_REA_DIV   = 7'h25;
	localparam logic [6:0] OFF_APP_DIV   = 7'h26;
	localparam logic [6:0] OFF_P1_NUM    = 7'h27;
	localparam logic [6:0] OFF_P1_DEN    = 7'h28;
	localparam logic [6:0] OFF_P2_NUM    = 7'h29;
	localparam logic [6:0] OFF_P2_DEN    = 7'h2a;
	localparam logic [6:0] OFF_ZX_CTRL   = 7'h2b;
	localparam logic [6:0] OFF_RSVD_A    = 7'h3b;
	localparam logic [6:0] OFF_RSVD_B    = 7'h3c;
	localparam logic [6:0] OFF_CAL_MODE  = 7'h3d;
	localparam logic [6:0] OFF_RSVD_C    = 7'h3e;
	localparam logic [6:0] OFF_RSVD_D    = 7'h3f;

	// Reset values that are not zero.
	localparam logic [15:0] RST_LINE_CYC = 16'hffff;
	localparam logic [7:0]  RST_SAG_CYC  = 8'hff;
	localparam logic [15:0] RST_PK_THR   = 16'hffff;
	localparam logic [15:0] RST_P_DEN    = 16'h003f;
	localparam logic [15:0] RST_RSVD_B   = 16'h0300;

	// Sample stream from the metering datapath, all on the core clock.
	typedef struct packed {
		logic               vld;
		logic               zx;
		logic [23:0]        i_abs;
		logic [23:0]        v_abs;
		logic signed [23:0] e_act;
		logic signed [23:0] e_rea;
		logic signed [23:0] e_app;
	} emcr_smp_t;

	typedef struct packed {
		logic [15:0] line_cycle_count;
		logic [7:0]  sag_half_cycle_count;
		logic [15:0] sag_threshold;
		logic [15:0] current_peak_threshold;
		logic [15:0] voltage_peak_threshold;
		logic [7:0]  input_amp_gain;
		logic [11:0] second_current_match_gain;
		logic [11:0] active_power_gain;
		logic [11:0] reactive_power_gain;
		logic [11:0] apparent_power_gain;
		logic [15:0] active_power_offset;
		logic [15:0] reactive_power_offset;
		logic [11:0] current_rms_offset;
		logic [11:0] voltage_rms_offset;
		logic [7:0]  active_energy_divider;
		logic [7:0]  reactive_energy_divider;
		logic [7:0]  apparent_energy_divider;
		logic [15:0] pulse_out1_numerator;
		logic [15:0] pulse_out1_denominator;
		logic [15:0] pulse_out2_numerator;
		logic [15:0] pulse_out2_denominator;
		logic [7:0]  zero_cross_output_ctrl;
		logic [7:0]  calibration_mode_sel;
		logic [7:0]  reserved_word_a;
		logic [15:0] reserved_word_b;
		logic [7:0]  reserved_word_c;
		logic [7:0]  reserved_word_d;
	} emcr_cfg_t;

endpackage : emcr_pkg

// File: src/emcr_peak_hold.sv
// Peak hold with read-clear and threshold compare for one measurement channel.
`timescale 1ns/10ps
module emcr_peak_hold #(
	parameter int W = 24
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         smp_vld,
	input  wire logic [W-1:0] smp,
	input  wire logic [15:0]  thr,
	input  wire logic         clr,
	output logic [W-1:0]      peak_q,
	output logic              over_q
);
	if (W < 16) begin : g_bad_width
		$error("emcr_peak_hold needs W of at least 16");
	end

	logic [W-1:0] base;
	logic         grow;

	// A sample arriving with the clear is compared against zero, so it is kept.
	assign base = clr ? '0 : peak_q;
	assign grow = smp_vld && (smp > base);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			peak_q <= '0;
			over_q <= 1'b0;
		end else begin
			peak_q <= grow ? smp : base;
			over_q <= smp_vld && (smp[W-1 -: 16] > thr);
		end
	end
endmodule : emcr_peak_hold

// File: src/emcr_line_accum.sv
// Line-cycle synchronous energy accumulators, one per energy channel.
`timescale 1ns/10ps
module emcr_line_accum #(
	parameter int W  = 24,
	parameter int CH = 3
) (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                e_vld,
	input  wire logic [CH-1:0][W-1:0] energy,
	input  wire logic                zx,
	input  wire logic [15:0]         half_cycles,
	output logic [CH-1:0][W-1:0]     total_q,
	output logic                     done_q
);
	if (W < 2 || CH < 1) begin : g_bad_param
		$error("emcr_line_accum needs W of at least 2 and CH of at least 1");
	end

	logic [16:0] hc_q;
	logic [16:0] hc_next;
	logic        latch;

	// A count of zero latches on every crossing rather than never.
	assign hc_next = hc_q + 17'h00001;
	assign latch   = zx && (hc_next >= {1'b0, half_cycles});

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hc_q   <= '0;
			done_q <= 1'b0;
		end else begin
			hc_q   <= latch ? '0 : (zx ? hc_next : hc_q);
			done_q <= latch;
		end
	end

	for (genvar c = 0; c < CH; c++) begin : g_ch
		logic [W-1:0] acc_q;
		logic [W-1:0] acc_sum;
		assign acc_sum = acc_q + (e_vld ? energy[c] : '0);
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				acc_q      <= '0;
				total_q[c] <= '0;
			end else begin
				acc_q <= latch ? '0 : acc_sum;
				if (latch) begin
					total_q[c] <= acc_sum;
				end
			end
		end
	end
endmodule : emcr_line_accum

// File: tb/emcr_regs_asserts.sv
// Port-level assertions for the indirect register bank.
`timescale 1ns/10ps
module emcr_regs_asserts (
	input logic                clock,
	input logic                rst_n,
	input logic                sfr_wr,
	input logic                sfr_rd,
	input logic [7:0]          sfr_addr,
	input logic [7:0]          sfr_wdata,
	input logic [7:0]          sfr_rdata_q,
	input emcr_pkg::emcr_smp_t smp,
	input emcr_pkg::emcr_cfg_t cfg_q,
	input logic [2:0][23:0]    line_energy_q,
	input logic                line_done_q,
	input logic                sag_q,
	input logic                current_over_q,
	input logic                voltage_over_q
);
	logic [7:0] lo_q;
	wire        wcmd = sfr_wr && sfr_addr == emcr_pkg::SFR_PTR && sfr_wdata[7];
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lo_q <= 8'h00;
		end else if (sfr_wr && sfr_addr == emcr_pkg::SFR_DAT_LOW) begin
			lo_q <= sfr_wdata;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	rst_count_a: assert property ($rose(rst_n) |-> cfg_q.line_cycle_count == 16'hffff
		&& cfg_q.sag_half_cycle_count == 8'hff) else $error("count defaults wrong");
	rst_thr_a: assert property ($rose(rst_n) |-> cfg_q.sag_threshold == 16'h0000
		&& (cfg_q.current_peak_threshold & cfg_q.voltage_peak_threshold) == 16'hffff)
		else $error("threshold defaults wrong");
	rst_pulse_a: assert property ($rose(rst_n) |-> cfg_q.pulse_out1_denominator == 16'h003f
		&& cfg_q.pulse_out2_denominator == 16'h003f && cfg_q.pulse_out1_numerator == 16'h0000)
		else $error("pulse scaling defaults wrong");
	rst_rdata_a: assert property ($rose(rst_n) |-> sfr_rdata_q == 8'h00)
		else $error("read data not cleared");
	rd_hold_a: assert property ($past(rst_n) && !sfr_rd |=> $stable(sfr_rdata_q))
		else $error("read data moved without a read");
	cfg_quiet_a: assert property ($past(rst_n) && !$past(wcmd) |-> $stable(cfg_q))
		else $error("config moved without a write command");
	narrow_wr_a: assert property (wcmd && sfr_wdata[6:0] == emcr_pkg::OFF_SAG_CYC
		|=> cfg_q.sag_half_cycle_count == $past(lo_q)) else $error("sag count write wrong");
	cur_over_a: assert property (smp.vld && smp.i_abs[23:8] > cfg_q.current_peak_threshold
		|=> current_over_q) else $error("current over flag missing");
	volt_over_a: assert property (smp.vld && smp.v_abs[23:8] > cfg_q.voltage_peak_threshold
		|=> voltage_over_q) else $error("voltage over flag missing");
	line_latch_a: assert property ($past(rst_n) && $changed(line_energy_q) |-> line_done_q)
		else $error("totals moved without done");
	cover property (wcmd);
	cover property (line_done_q);
	cover property (current_over_q && voltage_over_q);
endmodule : emcr_regs_asserts

bind emcr_regs emcr_regs_asserts u_asserts (
	.clock         (clock),
	.rst_n         (rst_n),
	.sfr_wr        (sfr_wr),
	.sfr_rd        (sfr_rd),
	.sfr_addr      (sfr_addr),
	.sfr_wdata     (sfr_wdata),
	.sfr_rdata_q   (sfr_rdata_q),
	.smp           (smp),
	.cfg_q         (cfg_q),
	.line_energy_q (line_energy_q),
	.line_done_q   (line_done_q),
	.sag_q         (sag_q),
	.current_over_q(current_over_q),
	.voltage_over_q(voltage_over_q)
);

// File: tb/emcr_core_model.sv
// Behavioural model of the core reaching the bank through its pointer registers.
`timescale 1ns/10ps
module emcr_core_model (
	input  logic       clock,
	output logic       sfr_wr,
	output logic       sfr_rd,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input  logic [7:0] sfr_rdata_q
);
	initial begin
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
	end
	// Released lines are inverted so a stale byte never passes for a live one.
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clock);
		sfr_wr <= 1'b0;
		sfr_addr <= ~a;
		sfr_wdata <= ~d;
	endtask : sfr_write
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clock);
		sfr_rd <= 1'b0;
		sfr_addr <= ~a;
		@(posedge clock);
		d = sfr_rdata_q;
	endtask : sfr_read
	task automatic reg_write(input logic [6:0] o, input logic [23:0] v);
		sfr_write(8'h92, v[7:0]);
		sfr_write(8'h93, v[15:8]);
		sfr_write(8'h94, v[23:16]);
		sfr_write(8'h91, {1'b1, o});
	endtask : reg_write
	task automatic reg_read(input logic [6:0] o, output logic [23:0] v);
		sfr_write(8'h91, {1'b0, o});
		sfr_read(8'h92, v[7:0]);
		sfr_read(8'h93, v[15:8]);
		sfr_read(8'h94, v[23:16]);
	endtask : reg_read
endmodule : emcr_core_model

// File: tb/tb_energy_meter_config_regs.sv
// Testbench: defaults, readback, peak reads and line-cycle totals.
`timescale 1ns/10ps
module tb_energy_meter_config_regs;
	logic                clock = 1'b0;
	logic                rst_n = 1'b0;
	logic                sfr_wr, sfr_rd;
	logic [7:0]          sfr_addr, sfr_wdata, sfr_rdata_q;
	emcr_pkg::emcr_smp_t smp = '0;
	emcr_pkg::emcr_cfg_t cfg_q;
	logic [2:0][23:0]    line_energy_q;
	logic                line_done_q, sag_q, current_over_q, voltage_over_q;
	logic [23:0]         v, p;
	int                  fail_count = 0, checked = 0, dn = 0;

	always #2.5 clock = ~clock;
	always @(posedge clock) if (line_done_q === 1'b1) dn++;

	emcr_core_model u_core (.clock(clock), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q));
	emcr_regs i_emcr_regs (.clock(clock), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .smp(smp),
		.cfg_q(cfg_q), .line_energy_q(line_energy_q), .line_done_q(line_done_q), .sag_q(sag_q),
		.current_over_q(current_over_q), .voltage_over_q(voltage_over_q));

	function automatic logic [23:0] rst_v(input int o);
		case (o)
			8'h12, 8'h15, 8'h16: rst_v = 24'h00ffff;
			8'h13: rst_v = 24'h0000ff;
			8'h28, 8'h2a: rst_v = 24'h00003f;
			8'h3c: rst_v = 24'h000300;
			default: rst_v = 24'h000000;
		endcase
	endfunction : rst_v

	function automatic logic [23:0] exp_w(input int o, input logic [23:0] d);
		case (o)
			8'h13, 8'h1b, 8'h24, 8'h25, 8'h26, 8'h2b, 8'h3d: exp_w = {16'h0000, d[7:0]};
			8'h12, 8'h14, 8'h15, 8'h16, 8'h27, 8'h28, 8'h29, 8'h2a: exp_w = {8'h00, d[15:0]};
			8'h20, 8'h21: exp_w = {{8{d[15]}}, d[15:0]};
			8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h22, 8'h23: exp_w = {{12{d[11]}}, d[11:0]};
			default: exp_w = rst_v(o);
		endcase
	endfunction : exp_w

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic summarize;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		u_core.sfr_read(8'hd1, v[7:0]);
		chk("unmapped sfr", 24'h0, {16'h0, v[7:0]});
		for (int i = 8'h12; i <= 8'h3f; i++) begin
			u_core.reg_read(7'(i), v);
			chk("reset value", rst_v(i), v);
		end
		u_core.sfr_read(8'h91, v[7:0]);
		chk("pointer readback", 24'h00003f, {16'h0, v[7:0]});
		for (int k = 0; k < 2; k++) begin
			p = k ? 24'ha5a5a5 : 24'h5a5a5a;
			for (int i = 8'h12; i <= 8'h3f; i++) begin
				if (!(i inside {8'h3b, 8'h3c, 8'h3e, 8'h3f})) u_core.reg_write(7'(i), p);
			end
			for (int i = 8'h12; i <= 8'h3f; i++) begin
				u_core.reg_read(7'(i), v);
				chk("readback", exp_w(i, p), v);
			end
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		u_core.reg_write(7'h15, 24'h001233);
		u_core.reg_write(7'h16, 24'h006542);
		@(posedge clock);
		smp.vld <= 1'b1;
		smp.i_abs <= 24'h123456;
		smp.v_abs <= 24'h654321;
		@(posedge clock);
		smp.vld <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			p = k ? 24'h654321 : 24'h123456;
			u_core.reg_read(7'(8'h17 + 2 * k), v);
			chk("peak", p, v);
			u_core.reg_read(7'(8'h18 + 2 * k), v);
			chk("peak clearing read", p, v);
			u_core.reg_read(7'(8'h17 + 2 * k), v);
			chk("peak after clear", 24'h0, v);
		end
		u_core.reg_write(7'h12, 24'h000002);
		smp.e_act <= 24'h00000a;
		smp.e_rea <= 24'hfffffd;
		smp.e_app <= 24'h000005;
		for (int j = 0; j < 4; j++) begin
			@(posedge clock);
			smp.vld <= 1'b1;
			smp.zx <= j[0];
			@(posedge clock);
			smp.vld <= 1'b0;
			smp.zx <= 1'b0;
		end
		repeat (3) @(posedge clock);
		chk("line done pulses", 24'h000001, 24'(dn));
		chk("line active total", 24'h000028, line_energy_q[0]);
		chk("line reactive total", 24'hfffff4, line_energy_q[1]);
		chk("line apparent total", 24'h000014, line_energy_q[2]);
		// A sample equal to the threshold is not above it, so those half cycles count as low.
		u_core.reg_write(7'h13, 24'h000002);
		u_core.reg_write(7'h14, 24'h006543);
		for (int j = 0; j < 5; j++) begin
			@(posedge clock);
			smp.vld <= 1'b1;
			smp.zx <= 1'b1;
			smp.v_abs <= (j < 3) ? 24'h654321 : 24'h654400;
			@(posedge clock);
			smp.vld <= 1'b0;
			smp.zx <= 1'b0;
			@(posedge clock);
			if (j == 2) chk("sag after low halves", 24'h000001, {23'h0, sag_q});
		end
		chk("sag after high half", 24'h000000, {23'h0, sag_q});
		summarize();
	end
endmodule : tb_energy_meter_config_regs
